// [rtl/frame_irq_pkg.sv]
// shared constants and carrier types for the read-out framing block
package frame_irq_pkg;

  // ----------------------------------------------------------------
  // register offsets (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_HDR_PAT   = 8'h14;
  localparam logic [7:0] OFS_TRL_PAT   = 8'h15;
  localparam logic [7:0] OFS_LEN_POP   = 8'h16;
  localparam logic [7:0] OFS_BUF_IRQ   = 8'h17;
  localparam logic [7:0] OFS_TDC_MASK  = 8'h18;
  localparam logic [7:0] OFS_LINK_IRQ  = 8'h19;
  localparam logic [7:0] OFS_ID_ERR    = 8'h1a;
  localparam logic [7:0] OFS_LINK_CTRL = 8'h1b;
  localparam logic [7:0] OFS_PART_EN   = 8'h21;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_HDR_PAT   = 8'h89;
  localparam logic [7:0]  RST_TRL_PAT   = 8'h8a;
  localparam logic [17:0] RST_TDC_MASK  = 18'h3ffff;
  localparam logic [17:0] RST_PART_EN   = 18'h3ffff;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NTDC          = 18;  // tdc slots per channel
  localparam int PAT_LSB       = 24;  // pattern byte in header/trailer
  localparam int TRL_ID_LSB    = 12;  // event id in trailer
  localparam int LEN_ID_LSB    = 16;  // event id in length entry
  localparam int BUF_MASK_LSB  = 4;   // mask nibble of buffer irq reg
  localparam int BUF_FLAG_LSB  = 8;   // per-tdc error flags
  localparam int BUF_OVR_BIT   = 26;  // tdc error overrun
  localparam int TDC_ERR_BIT   = 27;  // tdc error flag in input word
  localparam int PAR_BIT       = 26;  // link parity bit
  localparam int EVEN_PAR_BIT  = 9;   // parity select in link ctrl
  localparam int LDOWN_BIT     = 8;   // link status in link ctrl
  localparam int LNK_OVR_BIT   = 1;
  localparam int LNK_STAT_BIT  = 2;
  localparam int LNK_PMASK_BIT = 4;
  localparam int LNK_DMASK_BIT = 5;
  localparam int ID_EARLY_BIT  = 17;
  localparam int ID_LATE_BIT   = 18;
  localparam int ID_OVR_BIT    = 19;

  // length fifo size
  localparam int LEN_DEPTH = 16;
  localparam int LEN_AW    = 4;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [11:0] event_id;
    logic [17:0] status;    // per-tdc completion status
  } evt_req_t;

  typedef struct packed {
    logic [11:0] event_id;
    logic [4:0]  slot;
    logic        early;
    logic        late;
  } id_err_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HDR   = 2'b01,
    ST_DATA  = 2'b10,
    ST_TRL   = 2'b11
  } frame_st_t;

endpackage

// [rtl/readout_frame_irq_ctrl.sv]
// read-out framing, length fifo and interrupt logic for one channel
`timescale 1ns/10ps
module readout_frame_irq_ctrl (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // register port
  input  wire frame_irq_pkg::bus_req_t  bus,
  output logic [31:0]                   rdata,
  // event request fifo side
  input  wire logic                     req_valid,
  input  wire frame_irq_pkg::evt_req_t  req,
  output logic                          req_ready,
  // tdc data from partitions
  input  wire logic                     tdc_valid,
  input  wire logic [31:0]              tdc_data,
  input  wire logic                     tdc_end,
  output logic                          tdc_ready,
  // output fifo write side
  input  wire logic                     out_full,
  output logic                          out_valid,
  output logic [31:0]                   out_data,
  // status events from the rest of the channel
  input  wire logic                     req_fifo_full_evt,
  input  wire logic                     part_full_evt,
  input  wire logic                     max_size_evt,
  input  wire logic [4:0]               max_size_slot,
  input  wire logic                     link_valid,
  input  wire logic [31:0]              link_word,
  input  wire logic [4:0]               link_slot,
  input  wire logic                     link_down_n,
  input  wire logic                     id_err_valid,
  input  wire frame_irq_pkg::id_err_t   id_err,
  // outputs to host and read-out sequencer
  output logic [17:0]                   part_enable,
  output logic                          len_nonempty,
  output logic                          buffer_fault_irq_n,
  output logic                          buffer_fault_irq_n_oe,
  output logic                          link_error_irq_n,
  output logic                          link_error_irq_n_oe,
  output logic                          event_id_irq_n,
  output logic                          event_id_irq_n_oe
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_hdr  = bus.wr && bus.addr == frame_irq_pkg::OFS_HDR_PAT;
  wire wr_trl  = bus.wr && bus.addr == frame_irq_pkg::OFS_TRL_PAT;
  wire wr_buf  = bus.wr && bus.addr == frame_irq_pkg::OFS_BUF_IRQ;
  wire wr_tmsk = bus.wr && bus.addr == frame_irq_pkg::OFS_TDC_MASK;
  wire wr_lnk  = bus.wr && bus.addr == frame_irq_pkg::OFS_LINK_IRQ;
  wire wr_id   = bus.wr && bus.addr == frame_irq_pkg::OFS_ID_ERR;
  wire wr_lctl = bus.wr && bus.addr == frame_irq_pkg::OFS_LINK_CTRL;
  wire wr_pen  = bus.wr && bus.addr == frame_irq_pkg::OFS_PART_EN;
  wire rd_len  = bus.rd && bus.addr == frame_irq_pkg::OFS_LEN_POP;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  hdr_pat_q, trl_pat_q;     // pattern bytes
  logic [17:0] tdc_mask_q;               // individual tdc error mask
  logic [17:0] part_en_q;                // partition read-out enable
  logic        even_par_q;               // link parity select
  logic [3:0]  buf_pend_q, buf_mask_q;   // buffer fault pending / mask
  logic [17:0] tdc_flag_q;               // per-tdc error flags
  logic        tdc_ovr_q;                // tdc error overrun
  logic        par_pend_q, par_ovr_q;    // link parity pending / overrun
  logic [1:0]  lnk_mask_q;               // parity and link-down masks
  logic [18:0] id_cap_q;                 // early/late, slot, event id
  logic        id_pend_q, id_ovr_q;      // id irq pending / overrun
  logic        ldn_meta_q, ldn_q;        // link-down synchroniser

  // link-down arrives from a pin: two flops before use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ldn_meta_q <= 1'b1;
      ldn_q      <= 1'b1;
    end else begin
      ldn_meta_q <= link_down_n;
      ldn_q      <= ldn_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // framing state machine
  // ----------------------------------------------------------------
  frame_irq_pkg::frame_st_t st_q, st_d;
  logic [11:0] cnt_q, id_q;              // word count, event id
  logic [17:0] hstat_q;                  // header status latched
  logic        len_full;

  wire take_req = req_valid && req_ready;
  wire take_tdc = tdc_valid && tdc_ready;
  wire hdr_go   = st_q == frame_irq_pkg::ST_HDR && !out_full;
  // trailer waits for both output room and a free length slot
  wire trl_go   = st_q == frame_irq_pkg::ST_TRL && !out_full && !len_full;

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      frame_irq_pkg::ST_IDLE: begin
        if (take_req) st_d = frame_irq_pkg::ST_HDR;
      end
      frame_irq_pkg::ST_HDR: begin
        if (hdr_go) st_d = frame_irq_pkg::ST_DATA;
      end
      frame_irq_pkg::ST_DATA: begin
        if (tdc_end && !take_tdc) st_d = frame_irq_pkg::ST_TRL;
      end
      default: begin
        if (trl_go) st_d = frame_irq_pkg::ST_IDLE;
      end
    endcase
  end

  // header and trailer words
  wire [31:0] hdr_word = {hdr_pat_q, 6'h00,
                          hstat_q & part_en_q};
  wire [11:0] trl_cnt  = cnt_q + 12'h001;  // trailer counts itself
  wire [31:0] trl_word = {trl_pat_q, id_q, trl_cnt};
  wire [31:0] len_word = {4'h0, id_q, 4'h0, trl_cnt};

  // state, count and output word; data is stalled by out_full
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= frame_irq_pkg::ST_IDLE;
      cnt_q     <= 12'h000;
      id_q      <= 12'h000;
      hstat_q   <= 18'h00000;
      out_valid <= 1'b0;
      out_data  <= 32'h0000_0000;
      req_ready <= 1'b0;
      tdc_ready <= 1'b0;
    end else begin
      st_q      <= st_d;
      req_ready <= st_d == frame_irq_pkg::ST_IDLE && !take_req;
      tdc_ready <= st_d == frame_irq_pkg::ST_DATA && !out_full;
      out_valid <= hdr_go || take_tdc || trl_go;
      if (take_req) begin
        id_q    <= req.event_id;
        hstat_q <= req.status;
        cnt_q   <= 12'h000;
      end
      if (hdr_go) begin
        out_data <= hdr_word;
        cnt_q    <= 12'h001;
      end else if (take_tdc) begin
        out_data <= tdc_data;
        cnt_q    <= cnt_q + 12'h001;
      end else if (trl_go) begin
        out_data <= trl_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // event length fifo
  // ----------------------------------------------------------------
  logic [31:0]  len_mem [frame_irq_pkg::LEN_DEPTH];
  logic [frame_irq_pkg::LEN_AW:0] wp_q, rp_q;
  logic [31:0]  len_last_q;              // last value popped

  wire len_empty = wp_q == rp_q;
  assign len_full = wp_q == {~rp_q[frame_irq_pkg::LEN_AW],
                             rp_q[frame_irq_pkg::LEN_AW-1:0]};
  wire len_pop   = rd_len && !len_empty;
  wire [frame_irq_pkg::LEN_AW:0] wp_d = wp_q + {4'h0, trl_go};
  wire [frame_irq_pkg::LEN_AW:0] rp_d = rp_q + {4'h0, len_pop};

  // memory write has no reset; pointers do
  always_ff @(posedge clock) begin
    if (trl_go) len_mem[wp_q[frame_irq_pkg::LEN_AW-1:0]] <= len_word;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_q         <= '0;
      rp_q         <= '0;
      len_last_q   <= 32'h0000_0000;
      len_nonempty <= 1'b0;
    end else begin
      wp_q         <= wp_d;
      rp_q         <= rp_d;
      len_nonempty <= wp_d != rp_d;
      // an empty read leaves the old value to be read again
      if (len_pop) len_last_q <= len_mem[rp_q[frame_irq_pkg::LEN_AW-1:0]];
    end
  end

  // ----------------------------------------------------------------
  // buffer fault interrupt
  // ----------------------------------------------------------------
  wire tdc_err_raw = link_valid && link_word[frame_irq_pkg::TDC_ERR_BIT];
  wire slot_ok     = link_slot < 5'd18;
  wire tdc_err_hit = tdc_err_raw && slot_ok &&
                     tdc_mask_q[link_slot];
  wire [3:0] buf_evt = {tdc_err_hit, max_size_evt,
                        part_full_evt, req_fifo_full_evt};
  wire [3:0] buf_set = buf_evt & buf_mask_q;
  wire [3:0] buf_clr = wr_buf ? bus.wdata[3:0] : 4'h0;
  wire [17:0] slot_hot = 18'h00001 << link_slot;
  wire tdc_first = buf_set[3] && !buf_pend_q[3];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf_pend_q <= 4'h0;
      buf_mask_q <= 4'h0;
      tdc_flag_q <= 18'h00000;
      tdc_ovr_q  <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle
      buf_pend_q <= (buf_pend_q & ~buf_clr) | buf_set;
      if (wr_buf) buf_mask_q <= bus.wdata[7:4];
      // flags keep the first error until it is serviced
      if (tdc_first) tdc_flag_q <= slot_hot;
      if (buf_set[3] && buf_pend_q[3]) tdc_ovr_q <= 1'b1;
      else if (buf_clr[3]) tdc_ovr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link error interrupt
  // ----------------------------------------------------------------
  wire par_odd  = ^link_word;
  wire par_bad  = link_valid &&
                  (even_par_q ? par_odd : !par_odd);
  wire par_clr  = wr_lnk && bus.wdata[0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      par_pend_q <= 1'b0;
      par_ovr_q  <= 1'b0;
      lnk_mask_q <= 2'b00;
    end else begin
      par_pend_q <= par_bad || (par_pend_q && !par_clr);
      if (par_bad && par_pend_q) par_ovr_q <= 1'b1;
      else if (par_clr) par_ovr_q <= 1'b0;
      if (wr_lnk) lnk_mask_q <= bus.wdata[5:4];
    end
  end

  // ----------------------------------------------------------------
  // event id error interrupt
  // ----------------------------------------------------------------
  wire [18:0] id_word = {id_err.late, id_err.early,
                         id_err.slot, id_err.event_id};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      id_pend_q <= 1'b0;
      id_ovr_q  <= 1'b0;
      id_cap_q  <= 19'h00000;
    end else begin
      // any write clears, but a new error in that cycle still wins
      id_pend_q <= id_err_valid || (id_pend_q && !wr_id);
      if (id_err_valid && id_pend_q) id_ovr_q <= 1'b1;
      else if (wr_id) id_ovr_q <= 1'b0;
      if (id_err_valid && (!id_pend_q || wr_id)) id_cap_q <= id_word;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // hardware clear of an oversize partition beats a software write
  wire [17:0] pen_hw_clr = max_size_evt ? (18'h00001 << max_size_slot)
                                        : 18'h00000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hdr_pat_q  <= frame_irq_pkg::RST_HDR_PAT;
      trl_pat_q  <= frame_irq_pkg::RST_TRL_PAT;
      tdc_mask_q <= frame_irq_pkg::RST_TDC_MASK;
      part_en_q  <= frame_irq_pkg::RST_PART_EN;
      even_par_q <= 1'b0;
    end else begin
      if (wr_hdr)  hdr_pat_q  <= bus.wdata[31:24];
      if (wr_trl)  trl_pat_q  <= bus.wdata[31:24];
      if (wr_tmsk) tdc_mask_q <= bus.wdata[17:0];
      if (wr_lctl) even_par_q <= bus.wdata[frame_irq_pkg::EVEN_PAR_BIT];
      part_en_q <= (wr_pen ? bus.wdata[17:0] : part_en_q)
                   & ~pen_hw_clr;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_d;
  wire  [31:0] len_rd = len_pop ? len_mem[rp_q[frame_irq_pkg::LEN_AW-1:0]]
                                : len_last_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (bus.addr == frame_irq_pkg::OFS_HDR_PAT) begin
      rd_d = {hdr_pat_q, 24'h000000};
    end else if (bus.addr == frame_irq_pkg::OFS_TRL_PAT) begin
      rd_d = {trl_pat_q, 24'h000000};
    end else if (bus.addr == frame_irq_pkg::OFS_LEN_POP) begin
      rd_d = len_rd;
    end else if (bus.addr == frame_irq_pkg::OFS_BUF_IRQ) begin
      rd_d = {5'h00, tdc_ovr_q, tdc_flag_q,
              buf_mask_q, buf_pend_q};
    end else if (bus.addr == frame_irq_pkg::OFS_TDC_MASK) begin
      rd_d = {14'h0000, tdc_mask_q};
    end else if (bus.addr == frame_irq_pkg::OFS_LINK_IRQ) begin
      rd_d = {26'h0000000, lnk_mask_q, 1'b0, ldn_q,
              par_ovr_q, par_pend_q};
    end else if (bus.addr == frame_irq_pkg::OFS_ID_ERR) begin
      rd_d = {12'h000, id_ovr_q, id_cap_q};
    end else if (bus.addr == frame_irq_pkg::OFS_LINK_CTRL) begin
      rd_d = {22'h000000, even_par_q, ldn_q, 8'h00};
    end else if (bus.addr == frame_irq_pkg::OFS_PART_EN) begin
      rd_d = {14'h0000, part_en_q};
    end
  end

  // ----------------------------------------------------------------
  // registered outputs: read data and open-drain interrupts
  // ----------------------------------------------------------------
  wire buf_irq = |(buf_pend_q & buf_mask_q);
  wire lnk_irq = (par_pend_q && lnk_mask_q[0]) ||
                 (!ldn_q && lnk_mask_q[1]);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata                 <= 32'h0000_0000;
      part_enable           <= frame_irq_pkg::RST_PART_EN;
      buffer_fault_irq_n    <= 1'b0;
      buffer_fault_irq_n_oe <= 1'b0;
      link_error_irq_n      <= 1'b0;
      link_error_irq_n_oe   <= 1'b0;
      event_id_irq_n        <= 1'b0;
      event_id_irq_n_oe     <= 1'b0;
    end else begin
      rdata                 <= bus.rd ? rd_d : 32'h0000_0000;
      part_enable           <= part_en_q;
      buffer_fault_irq_n_oe <= buf_irq;
      link_error_irq_n_oe   <= lnk_irq;
      event_id_irq_n_oe     <= id_pend_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence hdr_sent_s;
    hdr_go ##1 out_valid;
  endsequence

  hdr_pattern_a: assert property (@(posedge clock) disable iff (!rst_n)
    hdr_go |=> out_valid && out_data[31:24] == $past(hdr_pat_q))
    else $error("header pattern byte wrong");

  hdr_status_a: assert property (@(posedge clock) disable iff (!rst_n)
    hdr_sent_s |-> out_data[17:0] ==
      $past(hstat_q & part_en_q))
    else $error("header status bits wrong");

  trl_word_a: assert property (@(posedge clock) disable iff (!rst_n)
    trl_go |=> out_data == {$past(trl_pat_q), $past(id_q),
                            $past(cnt_q) + 12'h001})
    else $error("trailer word wrong");

  len_push_a: assert property (@(posedge clock) disable iff (!rst_n)
    trl_go && !len_pop |=> wp_q - rp_q == $past(wp_q - rp_q) + 5'd1)
    else $error("length entry not pushed with trailer");

  empty_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd_len && len_empty |=> rdata == $past(len_last_q))
    else $error("empty length read not repeating last value");

  buf_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
    !buf_pend_q[0] ##1 buf_pend_q[0] |-> $past(buf_mask_q[0]))
    else $error("pending bit set while masked");

  buf_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_buf && bus.wdata[1] && !buf_set[1] |=> !buf_pend_q[1])
    else $error("write one did not clear pending bit");

  par_fail_a: assert property (@(posedge clock) disable iff (!rst_n)
    par_bad && lnk_mask_q[0] && !wr_lnk |=> ##1 link_error_irq_n_oe)
    else $error("parity failure did not raise link irq");

  id_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_id && !id_err_valid |=> ##1 !event_id_irq_n_oe)
    else $error("write did not clear id irq");

  id_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    id_pend_q && !wr_id |=> $stable(id_cap_q))
    else $error("capture overwritten during overrun");

endmodule

// [bench/out_sink.sv]
// output fifo stand-in that records every word and can stall the writer
`timescale 1ns/10ps
module out_sink (
  input  wire logic        clock,
  input  wire logic        stall,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  output logic             out_full
);
  logic [31:0] words[$];  // words in arrival order
  // almost-full follows the bench's stall request
  assign out_full = stall;
  // take one word per write strobe
  always @(posedge clock) begin
    if (out_valid) begin
      words.push_back(out_data);
    end
  end
endmodule

// [bench/readout_frame_irq_ctrl_tb_top.sv]
// self-checking bench for the framing and interrupt block
`timescale 1ns/10ps
module readout_frame_irq_ctrl_tb_top;
  logic clock = 0, rst_n = 0, req_valid = 0, tdc_valid = 0, tdc_end = 0;
  logic link_valid = 0, id_err_valid = 0, stall = 0, link_down_n = 1;
  logic out_full, out_valid, req_ready, tdc_ready, len_nonempty;
  logic fi_oe, li_oe, ii_oe;
  logic [2:0] irq_lvl;  // open-drain data levels of the three pins
  logic [2:0] ev = '0;
  logic [4:0] max_size_slot = 5'd5, link_slot = 5'd3;
  logic [31:0] rdata, out_data, tdc_data = '0, link_word = '0, w;
  logic [17:0] part_enable;
  logic [7:0] hp;
  frame_irq_pkg::bus_req_t bus = '0;
  frame_irq_pkg::evt_req_t req = '0;
  frame_irq_pkg::id_err_t id_err = '0;
  int error_cnt = 0, cmp_count = 0;
  integer seed = 32'h93b501de;  // fixed seed keeps runs repeatable
  // 8 ns clock
  always #4 clock = ~clock;
  readout_frame_irq_ctrl uut (.clock(clock), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .tdc_valid(tdc_valid), .tdc_data(tdc_data), .tdc_end(tdc_end),
    .tdc_ready(tdc_ready), .out_full(out_full), .out_valid(out_valid),
    .out_data(out_data), .req_fifo_full_evt(ev[0]),
    .part_full_evt(ev[1]), .max_size_evt(ev[2]),
    .max_size_slot(max_size_slot), .link_valid(link_valid),
    .link_word(link_word), .link_slot(link_slot),
    .link_down_n(link_down_n), .id_err_valid(id_err_valid),
    .id_err(id_err), .part_enable(part_enable),
    .len_nonempty(len_nonempty), .buffer_fault_irq_n(irq_lvl[0]),
    .buffer_fault_irq_n_oe(fi_oe), .link_error_irq_n(irq_lvl[1]),
    .link_error_irq_n_oe(li_oe), .event_id_irq_n(irq_lvl[2]),
    .event_id_irq_n_oe(ii_oe));
  out_sink sink (.clock(clock), .stall(stall), .out_valid(out_valid),
    .out_data(out_data), .out_full(out_full));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) bus <= {a, d, 2'b10};
    @(posedge clock) bus <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock) bus <= {a, 32'h0, 2'b01};
    @(posedge clock) bus <= '0;
    #1 chk(rdata, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    rd(8'h14, 32'h89000000);
    rd(8'h11, 32'h0);
    hp = 8'($random(seed));
    wr(8'h14, {hp, 24'h0});
    // event with the output fifo stalled at first
    @(posedge clock) req <= 30'($random(seed));
    req_valid <= 1;
    stall <= 1;
    @(posedge clock) req_valid <= 0;
    tick(10);
    chk(sink.words.size(), 0);
    @(posedge clock) tdc_data <= $random(seed);
    tdc_valid <= 1;
    stall <= 0;
    @(negedge clock);
    while (tdc_ready !== 1'b1) @(negedge clock);
    @(posedge clock) tdc_valid <= 0;
    tdc_end <= 1;
    @(posedge clock) tdc_end <= 0;
    tick(6);
    chk(len_nonempty, 1);
    chk(sink.words[0], {hp, 6'h0, req.status});
    chk(sink.words[1], tdc_data);
    chk(sink.words.size(), 3);
    chk(req_ready, 1);
    chk(sink.words[2], {8'h8a, req.event_id, 12'h3});
    rd(8'h16, {4'h0, req.event_id, 4'h0, 12'h3});
    chk(len_nonempty, 0);
    rd(8'h16, {4'h0, req.event_id, 4'h0, 12'h3});
    // each of the three event-input buffer fault sources: raise, identify, clear
    wr(8'h17, 32'hf0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) ev <= 3'b1 << i;
      @(posedge clock) ev <= '0;
      tick(2);
      chk(fi_oe, 1);
      rd(8'h17, 32'hf0 | (1 << i));
      wr(8'h17, 32'hf0 | (1 << i));
      tick(2);
      chk(fi_oe, 0);
    end
    chk(part_enable, 18'h3ffdf);
    // second event: no data, trailer held back by a full output fifo
    @(posedge clock) req <= 30'($random(seed) | 32'h20);
    req_valid <= 1;
    tdc_end <= 1;
    @(posedge clock) req_valid <= 0;
    @(posedge clock) stall <= 1;
    tick(8);
    chk(len_nonempty, 0);
    chk(sink.words.size(), 4);
    @(posedge clock) stall <= 0;
    tdc_end <= 0;
    tick(4);
    chk(sink.words[3], {hp, 6'h0, req.status & 18'h3ffdf});
    chk(sink.words[4], {8'h8a, req.event_id, 12'h2});
    rd(8'h16, {4'h0, req.event_id, 4'h0, 12'h2});
    wr(8'h17, 32'h0);
    @(posedge clock) ev <= 3'b1;
    @(posedge clock) ev <= '0;
    tick(2);
    rd(8'h17, 32'h0);
    // two bad-parity words then a good one carrying a tdc error flag
    wr(8'h19, 32'h10);
    wr(8'h17, 32'h80);
    for (int i = 0; i < 3; i++) begin
      w = $random(seed);
      w[27] = (i == 2);
      w[26] = 0;
      w[26] = (i == 2) ^ (^w);
      @(posedge clock) link_word <= w;
      link_valid <= 1;
      @(posedge clock) link_valid <= 0;
      tick(2);
      chk(li_oe, 1);
    end
    rd(8'h19, 32'h17);
    rd(8'h17, 32'h888);
    // a second tdc error before service: overrun, flags keep slot 3
    @(posedge clock) link_slot <= 5'd7;
    link_valid <= 1;
    @(posedge clock) link_valid <= 0;
    tick(2);
    rd(8'h17, 32'h04000888);
    wr(8'h19, 32'h11);
    tick(2);
    chk(li_oe, 0);
    // link down: live status bit and masked interrupt
    @(posedge clock) link_down_n <= 0;
    tick(4);
    rd(8'h19, 32'h10);
    wr(8'h19, 32'h20);
    tick(2);
    chk(li_oe, 1);
    @(posedge clock) link_down_n <= 1;
    tick(4);
    chk(li_oe, 0);
    // out-of-window event id capture and clear
    @(posedge clock) id_err <= 19'($random(seed));
    id_err_valid <= 1;
    @(posedge clock) id_err_valid <= 0;
    tick(2);
    chk(ii_oe, 1);
    chk(irq_lvl, 3'b000);
    w = {13'h0, id_err.late, id_err.early, id_err.slot, id_err.event_id};
    rd(8'h1a, w);
    // a second error before service: overrun, first capture kept
    @(posedge clock) id_err <= 19'($random(seed));
    id_err_valid <= 1;
    @(posedge clock) id_err_valid <= 0;
    tick(2);
    rd(8'h1a, w | 32'h80000);
    wr(8'h1a, $random(seed));
    tick(2);
    chk(ii_oe, 0);
    report_and_stop();
  end
endmodule
